// File: design/sic_pkg.sv
// ----------
// Shared constants for the stepper indexer and chopper
// ----------
`default_nettype none
package sic_pkg;

  // ----------
  // Timing
  // ----------
  localparam int CLOCK_KHZ = 100000;
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int PWM_FREQ_KHZ = 50;
  localparam int PWM_CYCLES = CLOCK_KHZ / PWM_FREQ_KHZ;
  // Blanking and dead time are least times, so they round up
  localparam int BLANK_NS = 3750;
  localparam int BLANK_CYCLES = (BLANK_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int DEAD_NS = 400;
  localparam int DEAD_CYCLES = (DEAD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  // Fast part of mixed decay is a longest time, so it rounds down
  localparam int MIXED_FAST_NS = 2500;
  localparam int MIXED_FAST_CYCLES = MIXED_FAST_NS / CLOCK_PERIOD_NS;

  // ----------
  // Indexer
  // ----------
  localparam logic [6:0] HOME_POSITION = 7'h10;
  localparam logic [6:0] FULL_STEP_OFFSET = 7'h10;
  localparam logic [2:0] SEL_FULL = 3'h0;
  localparam logic [2:0] SEL_HALF = 3'h1;
  localparam logic [2:0] SEL_QUARTER = 3'h2;
  localparam logic [2:0] SEL_EIGHTH = 3'h3;
  localparam logic [2:0] SEL_SIXTEENTH = 3'h4;
  // Winding current in percent over one quarter turn, 1/32 step apart
  localparam logic [6:0] SINE_TABLE [0:32] = '{
    7'h00, 7'h05, 7'h0A, 7'h0F, 7'h14, 7'h18, 7'h1D, 7'h22, 7'h26, 7'h2B, 7'h2F,
    7'h33, 7'h38, 7'h3C, 7'h3F, 7'h43, 7'h47, 7'h4A, 7'h4D, 7'h50, 7'h53, 7'h56,
    7'h58, 7'h5A, 7'h5C, 7'h5E, 7'h60, 7'h61, 7'h62, 7'h63, 7'h64, 7'h64, 7'h64};

  // ----------
  // Register map
  // ----------
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DAC = 8'h08;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam int CTRL_MIXED_BIT = 0;
  localparam int STAT_POS_LSB = 0;
  localparam int STAT_HOME_BIT = 7;
  localparam int STAT_SEL_LSB = 8;
  localparam int STAT_DRIVE_BIT = 11;
  localparam int DAC_A_LSB = 0;
  localparam int DAC_A_NEG_BIT = 7;
  localparam int DAC_B_LSB = 8;
  localparam int DAC_B_NEG_BIT = 15;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Bridge sequencer states, Gray coded along off-dead-drive-dead-decay
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_DEAD_ON = 3'h1,
    ST_DRIVE = 3'h3,
    ST_DEAD_DECAY = 3'h2,
    ST_DECAY = 3'h6
  } sic_state_type;

endpackage

`default_nettype wire

// File: design/sic_bridge_chopper.sv
`timescale 1ns/1ps
`default_nettype none

// ----------
// One H-bridge: fixed-period chopper with blanking and dead time
// ----------
module sic_bridge_chopper (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Control
  input wire logic pwmStart,
  input wire logic driveAllow,
  input wire logic currentNegative,
  input wire logic currentZero,
  input wire logic chopTrip,
  input wire logic decayFast,
  input wire logic decayMixed,
  // Gate drive
  output logic firstHigh,
  output logic firstLow,
  output logic secondHigh,
  output logic secondLow
);

  sic_pkg::sic_state_type state_r, state_nxt;
  logic [8:0] count_r, count_nxt;
  logic fastPhase_r, fastPhase_nxt;
  logic negative_r;
  logic negNow;
  logic countDone;
  logic driveOn, fastOn, slowOn;

  assign countDone = (count_r == 9'h000);
  // Polarity only follows the indexer while every gate is off
  assign negNow = (state_r == sic_pkg::ST_OFF || state_r == sic_pkg::ST_DEAD_ON) ?
                  currentNegative : negative_r;

  // Next state of the sequencer
  always_comb begin
    state_nxt = state_r;
    fastPhase_nxt = fastPhase_r;
    count_nxt = countDone ? count_r : count_r - 9'h001;
    case (state_r)
      sic_pkg::ST_OFF: begin
        if (pwmStart && !currentZero) begin
          state_nxt = sic_pkg::ST_DEAD_ON;
          count_nxt = 9'(sic_pkg::DEAD_CYCLES - 1); // [R20]
        end
      end
      sic_pkg::ST_DEAD_ON: begin
        if (countDone) begin
          state_nxt = sic_pkg::ST_DRIVE;
          count_nxt = 9'(sic_pkg::BLANK_CYCLES - 1); // [R09]
        end
      end
      sic_pkg::ST_DRIVE: begin
        // Trip is looked at only once blanking ran out [R09] [R10]
        if (countDone && chopTrip) begin // [R06]
          state_nxt = sic_pkg::ST_DEAD_DECAY;
          count_nxt = 9'(sic_pkg::DEAD_CYCLES - 1); // [R20]
          fastPhase_nxt = decayFast | decayMixed; // [R11] [R18]
        end
      end
      sic_pkg::ST_DEAD_DECAY: begin
        if (countDone) begin
          state_nxt = sic_pkg::ST_DECAY;
          count_nxt = (fastPhase_r && decayMixed) ? 9'(sic_pkg::MIXED_FAST_CYCLES - 1) :
                      9'h000;
        end
      end
      sic_pkg::ST_DECAY: begin
        if (pwmStart && !currentZero) begin // [R06]
          state_nxt = sic_pkg::ST_DEAD_ON;
          count_nxt = 9'(sic_pkg::DEAD_CYCLES - 1); // [R20]
        end else if (fastPhase_r && decayMixed && countDone) begin // [R11]
          // Fast to slow swaps the half-bridge that was high to low, so dead time again
          state_nxt = sic_pkg::ST_DEAD_DECAY;
          count_nxt = 9'(sic_pkg::DEAD_CYCLES - 1); // [R20]
          fastPhase_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = sic_pkg::ST_OFF;
      end
    endcase
    if (!driveAllow) begin
      state_nxt = sic_pkg::ST_OFF; // [R19]
    end
  end

  // Gate pattern of the next state; registered so the pins never glitch
  assign driveOn = (state_nxt == sic_pkg::ST_DRIVE);
  assign fastOn = (state_nxt == sic_pkg::ST_DECAY) && fastPhase_nxt;
  assign slowOn = (state_nxt == sic_pkg::ST_DECAY) && !fastPhase_nxt;

  // Sequencer registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= sic_pkg::ST_OFF;
      count_r <= 9'h000;
      fastPhase_r <= 1'b0;
      negative_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      fastPhase_r <= fastPhase_nxt;
      negative_r <= negNow;
    end
  end

  // Gates: drive is first terminal high for positive current
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      firstHigh <= 1'b0;
      firstLow <= 1'b0;
      secondHigh <= 1'b0;
      secondLow <= 1'b0;
    end else begin
      firstHigh <= (driveOn && !negNow) || (fastOn && negNow); // [R12]
      secondLow <= (driveOn && !negNow) || (fastOn && negNow) || slowOn; // [R12]
      secondHigh <= (driveOn && negNow) || (fastOn && !negNow);
      firstLow <= (driveOn && negNow) || (fastOn && !negNow) || slowOn;
    end
  end

endmodule

`default_nettype wire

// File: design/sic_stepper_indexer_chopper.sv
// Function
// R01 - Each rising step edge moves the indexer to the next sequence entry.
// R02 - Rotation sense high walks forward, low walks the same sequence backward.
// R03 - After a resolution change, next step lands on a state valid for it.
// R04 - Home state is 45 degrees, taken at reset and while init is low.
// R05 - Select 0 full 71%, 1 half, 2 quarter, 3 eighth, 4 sixteenth, else 1/32.
// R06 - Bridge drives until trip, then stays off until next 50 kHz period.
// R07 - Trip compares five times sense voltage against the scaled reference.
// R08 - Internal DAC scales each winding reference from the indexer state.
// R09 - Sense ignored for 3.75 us after a bridge turns current on.
// R10 - Every on-phase lasts at least the blanking time. Disable or sleep still cuts an on-phase short.
// R11 - Fast, slow and mixed decay are supported after a chop.
// R12 - Positive current drives the first terminal above the second.
// R13 - Undriven direction, step, init and select inputs read low.
// R14 - Controller keeps steps under 250 kHz, high and low 1.9 us each.
// R15 - Controller waits 200 ns after enabling bridges before stepping.
// R16 - Controller waits 1 ms after leaving low power before stepping.
// R17 - Low-power request stops driving the motor.
// R18 - Decay select low picks slow decay, high picks fast decay. With the control mixed bit set, both levels give mixed decay.
// R19 - Drive only when enabled and awake; position is kept otherwise. Steps still move it while disabled but awake.
// R20 - Dead time separates turning off one FET and on its partner.
`timescale 1ns/1ps
`default_nettype none

module sic_stepper_indexer_chopper (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Step and direction interface
  input wire logic stepInput,
  input wire logic rotationSense,
  input wire logic [2:0] microstepSelect,
  input wire logic indexerInit_n,
  input wire logic bridgeDriveAllow_n,
  input wire logic lowPowerRequest_n,
  input wire logic decaySelect,
  // Chop comparator results, high once five times sense reaches reference
  input wire logic chopTripA,
  input wire logic chopTripB,
  // Bridge A gates
  output logic windingTerminalFirstHighA,
  output logic windingTerminalFirstLowA,
  output logic windingTerminalSecondHighA,
  output logic windingTerminalSecondLowA,
  // Bridge B gates
  output logic windingTerminalFirstHighB,
  output logic windingTerminalFirstLowB,
  output logic windingTerminalSecondHighB,
  output logic windingTerminalSecondLowB,
  // Reference DAC codes, percent of full scale
  output logic [6:0] chopReferenceScaleA,
  output logic [6:0] chopReferenceScaleB,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------
  // Step edge detection and indexer
  // ----------
  logic stepPrev_r;
  logic [6:0] position_r, position_nxt;
  logic stepRise, stepAccept, asleep, driveAllow;
  logic [6:0] stepSize, stepMask, stepOffset, relPos, relFwd, relRev, positionStep;
  logic relAligned;

  // Open pins are pulled low by the pads, so an idle step pin is no edge
  assign stepRise = stepInput && !stepPrev_r; // [R01] [R13]
  assign asleep = !lowPowerRequest_n; // [R17]
  assign driveAllow = !bridgeDriveAllow_n && lowPowerRequest_n; // [R19]
  // Steps are dropped while asleep or held in init
  assign stepAccept = stepRise && !asleep && indexerInit_n;

  // Step size in 1/32 units; codes above sixteenth all give 1/32
  assign stepSize = (microstepSelect == sic_pkg::SEL_FULL) ? 7'h20 : // [R05]
                    (microstepSelect == sic_pkg::SEL_HALF) ? 7'h10 :
                    (microstepSelect == sic_pkg::SEL_QUARTER) ? 7'h08 :
                    (microstepSelect == sic_pkg::SEL_EIGHTH) ? 7'h04 :
                    (microstepSelect == sic_pkg::SEL_SIXTEENTH) ? 7'h02 : 7'h01;
  // Full step sits on the 45 degree diagonals, the 71% points
  assign stepOffset = (microstepSelect == sic_pkg::SEL_FULL) ?
                      sic_pkg::FULL_STEP_OFFSET : 7'h00; // [R05]
  assign stepMask = ~(stepSize - 7'h01);
  assign relPos = position_r - stepOffset;
  assign relAligned = ((relPos & ~stepMask) == 7'h00);
  // Snapping to the grid of the new size makes a resolution change safe
  assign relFwd = (relPos & stepMask) + stepSize; // [R03]
  assign relRev = relAligned ? relPos - stepSize : (relPos & stepMask); // [R03]
  assign positionStep = (rotationSense ? relFwd : relRev) + stepOffset; // [R02]

  // Init pin wins over a step in the same cycle
  assign position_nxt = !indexerInit_n ? sic_pkg::HOME_POSITION : // [R04]
                        stepAccept ? positionStep : position_r; // [R01]

  // Indexer position, 128 states of 1/32 step per electrical turn
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stepPrev_r <= 1'b0;
      position_r <= sic_pkg::HOME_POSITION; // [R04]
    end else begin
      stepPrev_r <= stepInput;
      position_r <= position_nxt;
    end
  end

  // ----------
  // Current DAC lookup
  // ----------
  logic [1:0] quadrant;
  logic [5:0] tableFwd, tableRev;
  logic [6:0] sineFwd, sineRev, magA, magB;
  logic negA, negB;
  logic negA_r, negB_r;

  assign quadrant = position_r[6:5];
  assign tableFwd = {1'b0, position_r[4:0]};
  assign tableRev = 6'h20 - tableFwd;
  assign sineFwd = sic_pkg::SINE_TABLE[tableFwd];
  assign sineRev = sic_pkg::SINE_TABLE[tableRev];
  // Winding A is cosine, B is sine of the angle
  assign magA = quadrant[0] ? sineFwd : sineRev;
  assign magB = quadrant[0] ? sineRev : sineFwd;
  assign negA = quadrant[1] ^ quadrant[0];
  assign negB = quadrant[1];

  // Reference scale per winding, one cycle behind the position
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      chopReferenceScaleA <= 7'h00;
      chopReferenceScaleB <= 7'h00;
      negA_r <= 1'b0;
      negB_r <= 1'b0;
    end else begin
      chopReferenceScaleA <= magA; // [R08]
      chopReferenceScaleB <= magB; // [R08]
      negA_r <= negA;
      negB_r <= negB;
    end
  end

  // ----------
  // PWM period divider
  // ----------
  logic [10:0] pwmCount_r;
  logic pwmStart_r;
  logic pwmWrap;

  assign pwmWrap = (pwmCount_r == 11'(sic_pkg::PWM_CYCLES - 1));

  // One start pulse per 50 kHz period, shared by both bridges
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pwmCount_r <= 11'h000;
      pwmStart_r <= 1'b0;
    end else begin
      pwmCount_r <= pwmWrap ? 11'h000 : pwmCount_r + 11'h001;
      pwmStart_r <= pwmWrap; // [R06]
    end
  end

  // ----------
  // Bridges
  // ----------
  logic [31:0] control_r;
  logic decayMixed;

  assign decayMixed = control_r[sic_pkg::CTRL_MIXED_BIT]; // [R11]

  // Trip inputs already hold the five-times sense comparison [R07]
  sic_bridge_chopper bridgeA (
    .clock(clock),
    .reset_n(reset_n),
    .pwmStart(pwmStart_r),
    .driveAllow(driveAllow),
    .currentNegative(negA_r),
    .currentZero(chopReferenceScaleA == 7'h00),
    .chopTrip(chopTripA),
    .decayFast(decaySelect),
    .decayMixed(decayMixed),
    .firstHigh(windingTerminalFirstHighA),
    .firstLow(windingTerminalFirstLowA),
    .secondHigh(windingTerminalSecondHighA),
    .secondLow(windingTerminalSecondLowA)
  );

  sic_bridge_chopper bridgeB (
    .clock(clock),
    .reset_n(reset_n),
    .pwmStart(pwmStart_r),
    .driveAllow(driveAllow),
    .currentNegative(negB_r),
    .currentZero(chopReferenceScaleB == 7'h00),
    .chopTrip(chopTripB),
    .decayFast(decaySelect),
    .decayMixed(decayMixed),
    .firstHigh(windingTerminalFirstHighB),
    .firstLow(windingTerminalFirstLowB),
    .secondHigh(windingTerminalSecondHighB),
    .secondLow(windingTerminalSecondLowB)
  );

  // ----------
  // AXI4-Lite slave
  // ----------
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic awTake, wTake, writeDo, arTake;
  logic wrControl, wrKnown, rdKnown;
  logic [31:0] statusWord, dacWord, readWord;

  assign awTake = s_axi_awvalid && s_axi_awready;
  assign wTake = s_axi_wvalid && s_axi_wready;
  // Write runs once both halves are held and the last answer is gone
  assign writeDo = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign arTake = s_axi_arvalid && s_axi_arready;
  assign wrControl = ({awaddr_r[7:2], 2'h0} == sic_pkg::REG_CONTROL);
  assign wrKnown = wrControl || ({awaddr_r[7:2], 2'h0} == sic_pkg::REG_STATUS) ||
                   ({awaddr_r[7:2], 2'h0} == sic_pkg::REG_DAC);
  assign rdKnown = ({s_axi_araddr[7:2], 2'h0} == sic_pkg::REG_CONTROL) ||
                   ({s_axi_araddr[7:2], 2'h0} == sic_pkg::REG_STATUS) ||
                   ({s_axi_araddr[7:2], 2'h0} == sic_pkg::REG_DAC);

  // Read views of the block's own state
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[sic_pkg::STAT_POS_LSB +: 7] = position_r;
    statusWord[sic_pkg::STAT_HOME_BIT] = (position_r == sic_pkg::HOME_POSITION);
    statusWord[sic_pkg::STAT_SEL_LSB +: 3] = microstepSelect;
    statusWord[sic_pkg::STAT_DRIVE_BIT] = driveAllow;
    dacWord = 32'h0000_0000;
    dacWord[sic_pkg::DAC_A_LSB +: 7] = chopReferenceScaleA;
    dacWord[sic_pkg::DAC_A_NEG_BIT] = negA_r;
    dacWord[sic_pkg::DAC_B_LSB +: 7] = chopReferenceScaleB;
    dacWord[sic_pkg::DAC_B_NEG_BIT] = negB_r;
  end

  assign readWord = ({s_axi_araddr[7:2], 2'h0} == sic_pkg::REG_CONTROL) ? control_r :
                    ({s_axi_araddr[7:2], 2'h0} == sic_pkg::REG_STATUS) ? statusWord :
                    ({s_axi_araddr[7:2], 2'h0} == sic_pkg::REG_DAC) ? dacWord :
                    32'h0000_0000;

  // Write channels: address and data are taken in either order
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sic_pkg::RESP_OKAY;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (awTake) begin
        s_axi_awready <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end
      if (wTake) begin
        s_axi_wready <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (writeDo) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrKnown ? sic_pkg::RESP_OKAY : sic_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register, byte lanes honoured; status and DAC ignore writes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      control_r <= sic_pkg::CONTROL_RESET;
    end else if (writeDo && wrControl) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_r[b]) begin
          control_r[b*8 +: 8] <= wdata_r[b*8 +: 8];
        end
      end
    end
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= sic_pkg::RESP_OKAY;
    end else if (arTake) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readWord;
      s_axi_rresp <= rdKnown ? sic_pkg::RESP_OKAY : sic_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// File: tb/sic_stepper_indexer_chopper_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sic_stepper_indexer_chopper_sva (
  // Clock, reset and control pins
  input wire logic clock,
  input wire logic reset_n,
  input wire logic indexerInit_n,
  input wire logic bridgeDriveAllow_n,
  input wire logic lowPowerRequest_n,
  // Gates and reference codes
  input wire logic windingTerminalFirstHighA,
  input wire logic windingTerminalFirstLowA,
  input wire logic windingTerminalSecondHighA,
  input wire logic windingTerminalSecondLowA,
  input wire logic windingTerminalFirstHighB,
  input wire logic windingTerminalFirstLowB,
  input wire logic windingTerminalSecondHighB,
  input wire logic windingTerminalSecondLowB,
  input wire logic [6:0] chopReferenceScaleA,
  input wire logic [6:0] chopReferenceScaleB
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ----------
  // Run lengths of the first high gate of bridge A
  // ----------
  wire logic [7:0] gates = {windingTerminalFirstHighA, windingTerminalFirstLowA,
    windingTerminalSecondHighA, windingTerminalSecondLowA, windingTerminalFirstHighB,
    windingTerminalFirstLowB, windingTerminalSecondHighB, windingTerminalSecondLowB};
  logic [11:0] onCnt, offCnt;
  // Off count saturates so a long idle never wraps into a false short gap
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      onCnt <= 12'h000;
      offCnt <= 12'hFFF;
    end else begin
      onCnt <= gates[7] ? onCnt + 12'h001 : 12'h000;
      offCnt <= gates[7] ? 12'h000 : offCnt + {11'h000, ~&offCnt};
    end
  end
  shoot_thru_a: assert property (!(gates[7] && gates[6]) && !(gates[5] && gates[4]))
    else $error("bridge A half-bridge conducts both ways");
  b_shoot_thru_a: assert property (!(gates[3] && gates[2]) && !(gates[1] && gates[0]))
    else $error("bridge B half-bridge conducts both ways");
  dead_time_a: assert property ($rose(gates[6]) |-> offCnt >= sic_pkg::DEAD_CYCLES)
    else $error("low gate followed high gate too soon");
  blank_min_a: assert property (
    $fell(gates[7]) && !$past(bridgeDriveAllow_n) && $past(lowPowerRequest_n)
    |-> onCnt >= sic_pkg::BLANK_CYCLES) else $error("on-phase shorter than blanking");
  disable_off_a: assert property (bridgeDriveAllow_n |=> gates == 8'h00)
    else $error("gates driven while disabled");
  sleep_off_a: assert property (!lowPowerRequest_n |=> gates == 8'h00)
    else $error("gates driven while asleep");
  home_dac_a: assert property (
    !indexerInit_n [*2] |=> chopReferenceScaleA == 7'h47 && chopReferenceScaleB == 7'h47)
    else $error("reference codes not at home value");
  sleep_hold_a: assert property (
    (!lowPowerRequest_n && indexerInit_n) [*3] |->
    $stable(chopReferenceScaleA) && $stable(chopReferenceScaleB))
    else $error("reference codes moved while asleep");
  cover property ($fell(gates[7]));
  cover property (gates[6] && gates[4]);
  cover property (gates[6] && gates[5]);
endmodule
bind sic_stepper_indexer_chopper sic_stepper_indexer_chopper_sva sva_inst (.*);
`default_nettype wire

// File: tb/sic_step_controller.sv
`timescale 1ns/1ps
`default_nettype none
module sic_step_controller (
  // Clock
  input wire logic clock,
  // Step and direction pins
  output logic stepInput = 1'b0,
  output logic rotationSense = 1'b0
);
  // ----------
  // One step pulse; callers never step after a wake-up
  // ----------
  task automatic step_once(input logic forward, input int hold);
    @(posedge clock);
    rotationSense <= forward;
    // Setup wait also covers the delay after enabling the bridges
    repeat (20) @(posedge clock);
    stepInput <= 1'b1;
    repeat (hold) @(posedge clock);
    stepInput <= 1'b0;
    repeat (hold) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// File: tb/sic_stepper_indexer_chopper_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sic_stepper_indexer_chopper_tb;
  logic clock = 1'b0, reset_n = 1'b0, indexerInit_n = 1'b1, bridgeDriveAllow_n = 1'b1;
  logic lowPowerRequest_n = 1'b1, decaySelect = 1'b0, chopTripA = 1'b0, chopTripB = 1'b0;
  logic [2:0] microstepSelect = 3'h0;
  logic stepInput, rotationSense, windingTerminalFirstHighA, windingTerminalFirstLowA;
  logic windingTerminalSecondHighA, windingTerminalSecondLowA, windingTerminalFirstHighB;
  logic windingTerminalFirstLowB, windingTerminalSecondHighB, windingTerminalSecondLowB;
  logic [6:0] chopReferenceScaleA, chopReferenceScaleB;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  int errors = 0, checks = 0, cyc = 0, last = 0, len = 0;
  // Step table entries: {forward, select, expected position}
  logic [11:0] stepTab [8] = '{12'h830, 12'h42E, 12'h930, 12'hA38, 12'hB3C, 12'hD3D, 12'hE3E,
    12'h73D};
  wire logic [7:0] gatesAB = {windingTerminalFirstHighA, windingTerminalFirstLowA,
    windingTerminalSecondHighA, windingTerminalSecondLowA, windingTerminalFirstHighB,
    windingTerminalFirstLowB, windingTerminalSecondHighB, windingTerminalSecondLowB};
  sic_stepper_indexer_chopper sic_stepper_indexer_chopper_inst (.*);
  sic_step_controller sic_step_controller_inst (.clock, .stepInput, .rotationSense);
  initial begin
    forever #5 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;
  // ----------
  // Compare, close and bus tasks
  // ----------
  task automatic check(input string what, input logic [33:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // A wait that outlives any legal period counts as a hang
  task automatic give_up(input int k);
    if (k > 3000) begin
      errors++;
      $display("MISMATCH wait expected done seen timeout");
      end_sim();
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      give_up(++k);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      give_up(++k);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic wait_fh(input logic v, output int k);
    k = 0;
    do begin
      @(posedge clock);
      give_up(++k);
    end while (windingTerminalFirstHighA !== v);
  endtask
  // ----------
  // Main sequence
  // ----------
  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    axi_read(sic_pkg::REG_STATUS, rd, resp);
    check("home status", rd[7:0], 8'h90);
    check("home codes", {chopReferenceScaleA, chopReferenceScaleB}, 14'h23C7);
    axi_read(8'h0C, rd, resp);
    check("unmapped read", {rd, resp}, {32'h0, sic_pkg::RESP_SLVERR});
    axi_write(sic_pkg::REG_STATUS, 32'h0, resp);
    check("status write", resp, sic_pkg::RESP_OKAY);
    axi_write(8'h0C, 32'h0, resp);
    check("unmapped write", resp, sic_pkg::RESP_SLVERR);
    axi_read(sic_pkg::REG_CONTROL, rd, resp);
    check("control reset", rd, sic_pkg::CONTROL_RESET);
    $display("test registers done");
    // Bridges stay disabled here, which must not stop the indexer
    foreach (stepTab[i]) begin
      microstepSelect <= stepTab[i][10:8];
      sic_step_controller_inst.step_once(stepTab[i][11], 190 + 40 * i);
      axi_read(sic_pkg::REG_STATUS, rd, resp);
      check("position", rd[6:0], stepTab[i][6:0]);
    end
    axi_read(sic_pkg::REG_DAC, rd, resp);
    check("dac register", rd, 32'h0000_0FE3);
    $display("test stepping done");
    lowPowerRequest_n <= 1'b0;
    sic_step_controller_inst.step_once(1'b1, 190);
    axi_read(sic_pkg::REG_STATUS, rd, resp);
    check("sleep position", rd[6:0], 7'h3D);
    lowPowerRequest_n <= 1'b1;
    indexerInit_n <= 1'b0;
    repeat (3) @(posedge clock);
    indexerInit_n <= 1'b1;
    axi_read(sic_pkg::REG_STATUS, rd, resp);
    check("init status", rd[7:0], 8'h90);
    $display("test sleep and init done");
    // Trip held high, so every on-phase ends as soon as blanking allows
    chopTripA <= 1'b1;
    chopTripB <= 1'b1;
    bridgeDriveAllow_n <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      decaySelect <= (m == 1);
      axi_write(sic_pkg::REG_CONTROL, 32'(m == 2), resp);
      wait_fh(1'b1, len);
      check("drive", gatesAB, 8'h99);
      if (m > 0) check("period", cyc - last, sic_pkg::PWM_CYCLES);
      last = cyc;
      wait_fh(1'b0, len);
      check("on time", len >= sic_pkg::BLANK_CYCLES, 1'b1);
      repeat (60) @(posedge clock);
      check("decay", gatesAB, m == 0 ? 8'h55 : 8'h66);
      if (m == 2) begin
        repeat (300) @(posedge clock);
        check("mixed tail", gatesAB, 8'h55);
      end
    end
    bridgeDriveAllow_n <= 1'b1;
    repeat (3) @(posedge clock);
    check("disabled gates", gatesAB, 8'h00);
    $display("test chopper done");
    end_sim();
  end
endmodule
`default_nettype wire
